// File: hdl/vswcfg_regs.sv
`timescale 1ns/1ns

// Summary of operation
// - All config registers read/write over serial bus
// - Slave address low bits from strap pins
// - First serial access locks out parallel pins
// - Enable bit 0 standby, 1 channels on
// - Two-bit field selects fast source A-D
// - Auxiliary enable bit switches auxiliary path
// - Register 0x14 holds C/D equalizer bits
// - Two-bit field selects auxiliary source A-D
// - Pulse bit opens termination 100 ms on switch
// - Equalizer bit 0 low, 1 high level
// - Two-bit field sets output emphasis level
module vswcfg_regs
	import vswcfg_pkg::*;
#(
	parameter int TERM_PULSE_LEN = TERM_PULSE_CYCLES
) (
	input  wire logic        i_clk,
	input  wire logic        i_rst,
	input  wire logic        i_scl,
	input  wire logic        i_sda,
	output logic             o_sda_out,
	output logic             o_sda_oe,
	input  wire logic        i_slave_id_strap2,
	input  wire logic        i_slave_id_strap1,
	input  wire logic        i_slave_id_strap0,
	input  wire logic        i_par_fast_on,
	input  wire logic [1:0]  i_par_source_sel,
	input  wire logic        i_par_equalize,
	input  wire logic [1:0]  i_par_emphasis,
	input  wire logic        i_par_out_term,
	input  wire logic        i_par_out_current,
	output logic             o_serial_mode,
	output logic             o_fast_path_on,
	output logic [1:0]       o_fast_source_sel,
	output logic             o_side_path_on,
	output logic [1:0]       o_side_source_sel,
	output logic             o_input_term_on,
	output logic [15:0]      o_term_open_mask,
	output logic [15:0]      o_equalize_level_mask,
	output logic [1:0]       o_out_emphasis_level,
	output logic             o_out_term_on,
	output logic             o_out_current_level
);

	localparam int NPIN = 13;

	logic [NPIN-1:0] pin_s1_q, pin_s2_q, pin_s3_q, pin_f_q;
	logic [NPIN-1:0] pin_raw;
	logic            scl_f, sda_f, scl_prev_q, sda_prev_q;
	logic            scl_rise, scl_fall, bus_start, bus_stop;
	logic [6:0]      slave_id;

	vsw_state_t      state_q;
	logic [3:0]      bit_cnt_q;
	logic [1:0]      byte_idx_q;
	logic [7:0]      shift_q;
	logic [7:0]      reg_ptr_q;
	logic            read_q;
	logic            nack_q;
	logic            serial_q;
	logic            wr_stb;
	logic [7:0]      rd_byte;

	logic [7:0]      hs_modes_q, aux_modes_q, rx_set_q, tx_set_q;
	logic [15:0]     pulse_mask_q, eq_mask_q;

	logic [1:0]      eff_source, prev_source_q;
	logic [31:0]     pulse_cnt_q;

	function automatic logic [7:0] reg_read(input logic [7:0] ofs, input logic [7:0] hs, input logic [7:0] aux,
		input logic [7:0] rx, input logic [15:0] pt, input logic [15:0] eq, input logic [7:0] tx);
		logic [7:0] v;
		v = 8'h00;
		case (ofs)
			HIGH_SPEED_MODES_OFS:       v = hs;
			AUXILIARY_MODES_OFS:        v = aux;
			RECEIVER_SETTINGS_OFS:      v = rx;
			TERMINATION_PULSE_LOW_OFS:  v = pt[7:0];
			TERMINATION_PULSE_HIGH_OFS: v = pt[15:8];
			EQUALIZER_LOW_OFS:          v = eq[7:0];
			EQUALIZER_HIGH_OFS:         v = eq[15:8];
			TRANSMITTER_SETTINGS_OFS:   v = tx;
			default:                    v = 8'h00;
		endcase
		return v;
	endfunction : reg_read

	// Pin filtering: a change counts once stages two and three agree
	assign pin_raw = {i_par_fast_on, i_par_source_sel, i_par_equalize, i_par_emphasis, i_par_out_term,
		i_par_out_current, i_slave_id_strap2, i_slave_id_strap1, i_slave_id_strap0, i_sda, i_scl};

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			// Preset to idle-high so release never shows a false bus edge
			pin_s1_q <= 13'h1FFF;
			pin_s2_q <= 13'h1FFF;
			pin_s3_q <= 13'h1FFF;
			pin_f_q  <= 13'h1FFF;
		end else begin
			pin_s1_q <= pin_raw;
			pin_s2_q <= pin_s1_q;
			pin_s3_q <= pin_s2_q;
			pin_f_q  <= (pin_s2_q & ~(pin_s2_q ^ pin_s3_q)) | (pin_f_q & (pin_s2_q ^ pin_s3_q));
		end
	end

	assign scl_f    = pin_f_q[0];
	assign sda_f    = pin_f_q[1];
	assign slave_id = {SLAVE_ID_HIGH, pin_f_q[4:2]};

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			scl_prev_q <= 1'b1;
			sda_prev_q <= 1'b1;
		end else begin
			scl_prev_q <= scl_f;
			sda_prev_q <= sda_f;
		end
	end

	assign scl_rise  = scl_f & ~scl_prev_q;
	assign scl_fall  = ~scl_f & scl_prev_q;
	assign bus_start = scl_f & scl_prev_q & sda_prev_q & ~sda_f;
	assign bus_stop  = scl_f & scl_prev_q & ~sda_prev_q & sda_f;

	// Data byte completes on the falling edge after its eighth bit
	assign wr_stb = (state_q == VSW_SHIFT) && scl_fall && (bit_cnt_q == 4'd8) && (byte_idx_q == 2'd2);

	assign rd_byte = reg_read(reg_ptr_q, hs_modes_q, aux_modes_q, rx_set_q, pulse_mask_q, eq_mask_q, tx_set_q);

	// Serial slave; no auto-increment, pointer stays on its register
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			state_q    <= VSW_IDLE;
			bit_cnt_q  <= 4'd0;
			byte_idx_q <= 2'd0;
			shift_q    <= 8'h00;
			reg_ptr_q  <= 8'h00;
			read_q     <= 1'b0;
			nack_q     <= 1'b0;
			o_sda_oe   <= 1'b0;
		end else if (bus_start) begin
			state_q    <= VSW_SHIFT;
			bit_cnt_q  <= 4'd0;
			byte_idx_q <= 2'd0;
			o_sda_oe   <= 1'b0;
		end else if (bus_stop) begin
			state_q  <= VSW_IDLE;
			o_sda_oe <= 1'b0;
		end else begin
			case (state_q)
				VSW_SHIFT: begin
					if (scl_rise && bit_cnt_q != 4'd8) begin
						shift_q   <= {shift_q[6:0], sda_f};
						bit_cnt_q <= bit_cnt_q + 4'd1;
					end else if (scl_fall && bit_cnt_q == 4'd8) begin
						if (byte_idx_q == 2'd0 && shift_q[7:1] != slave_id) begin
							state_q <= VSW_IDLE;
						end else begin
							state_q  <= VSW_ACK;
							o_sda_oe <= 1'b1;
							if (byte_idx_q == 2'd0) begin
								read_q <= shift_q[0];
							end
							if (byte_idx_q == 2'd1) begin
								reg_ptr_q <= shift_q;
							end
						end
					end
				end
				VSW_ACK: begin
					if (scl_fall) begin
						if (byte_idx_q == 2'd0 && read_q) begin
							state_q   <= VSW_SEND;
							shift_q   <= rd_byte;
							o_sda_oe  <= ~rd_byte[7];
							bit_cnt_q <= 4'd0;
						end else begin
							state_q    <= VSW_SHIFT;
							o_sda_oe   <= 1'b0;
							bit_cnt_q  <= 4'd0;
							byte_idx_q <= (byte_idx_q == 2'd2) ? 2'd2 : byte_idx_q + 2'd1;
						end
					end
				end
				VSW_SEND: begin
					if (scl_fall) begin
						if (bit_cnt_q == 4'd7) begin
							state_q  <= VSW_MACK;
							o_sda_oe <= 1'b0;
						end else begin
							shift_q   <= {shift_q[6:0], 1'b0};
							o_sda_oe  <= ~shift_q[6];
							bit_cnt_q <= bit_cnt_q + 4'd1;
						end
					end
				end
				VSW_MACK: begin
					if (scl_rise) begin
						nack_q <= sda_f;
					end else if (scl_fall) begin
						if (nack_q) begin
							state_q <= VSW_IDLE;
						end else begin
							state_q   <= VSW_SEND;
							shift_q   <= rd_byte;
							o_sda_oe  <= ~rd_byte[7];
							bit_cnt_q <= 4'd0;
						end
					end
				end
				default: begin
					o_sda_oe <= 1'b0;
				end
			endcase
		end
	end

	// Open drain: only ever pulls low
	always_ff @(posedge i_clk) begin
		o_sda_out <= 1'b0;
	end

	// Any access that names this device counts as serial use
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			serial_q <= 1'b0;
		end else if (state_q == VSW_SHIFT && scl_fall && bit_cnt_q == 4'd8 && byte_idx_q == 2'd0
			&& shift_q[7:1] == slave_id) begin
			serial_q <= 1'b1;
		end
	end

	// Register writes, masked to defined bits
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			hs_modes_q   <= HIGH_SPEED_MODES_RST;
			aux_modes_q  <= AUXILIARY_MODES_RST;
			rx_set_q     <= RECEIVER_SETTINGS_RST;
			pulse_mask_q <= {TERMINATION_PULSE_RST, TERMINATION_PULSE_RST};
			eq_mask_q    <= {EQUALIZER_RST, EQUALIZER_RST};
			tx_set_q     <= TRANSMITTER_SETTINGS_RST;
		end else if (wr_stb) begin
			case (reg_ptr_q)
				HIGH_SPEED_MODES_OFS:       hs_modes_q <= shift_q & MODES_MASK;
				AUXILIARY_MODES_OFS:        aux_modes_q <= shift_q & MODES_MASK;
				RECEIVER_SETTINGS_OFS:      rx_set_q <= shift_q & RECEIVER_MASK;
				TERMINATION_PULSE_LOW_OFS:  pulse_mask_q[7:0] <= shift_q;
				TERMINATION_PULSE_HIGH_OFS: pulse_mask_q[15:8] <= shift_q;
				EQUALIZER_LOW_OFS:          eq_mask_q[7:0] <= shift_q;
				EQUALIZER_HIGH_OFS:         eq_mask_q[15:8] <= shift_q;
				TRANSMITTER_SETTINGS_OFS:   tx_set_q <= shift_q & TX_MASK;
				default: ;
			endcase
		end
	end

	assign eff_source = serial_q ? hs_modes_q[SOURCE_LSB +: 2] : pin_f_q[11:10];

	// Termination pulse restarts on every change of the routed source
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			prev_source_q <= 2'b00;
			pulse_cnt_q   <= 32'd0;
		end else begin
			prev_source_q <= eff_source;
			if (eff_source != prev_source_q) begin
				pulse_cnt_q <= 32'(TERM_PULSE_LEN);
			end else if (pulse_cnt_q != 32'd0) begin
				pulse_cnt_q <= pulse_cnt_q - 32'd1;
			end
		end
	end

	// Effective settings: serial bank once locked, parallel pins before, with aux path and input termination then forced on
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_serial_mode         <= 1'b0;
			o_fast_path_on        <= 1'b0;
			o_fast_source_sel     <= 2'b00;
			o_side_path_on        <= 1'b0;
			o_side_source_sel     <= 2'b00;
			o_input_term_on       <= 1'b0;
			o_term_open_mask      <= 16'h0000;
			o_equalize_level_mask <= 16'h0000;
			o_out_emphasis_level  <= 2'b00;
			o_out_term_on         <= 1'b0;
			o_out_current_level   <= 1'b0;
		end else begin
			o_serial_mode     <= serial_q;
			o_fast_source_sel <= eff_source;
			o_term_open_mask  <= (pulse_cnt_q != 32'd0) ? pulse_mask_q : 16'h0000;
			if (serial_q) begin
				o_fast_path_on        <= hs_modes_q[ENABLE_BIT];
				o_side_path_on        <= aux_modes_q[ENABLE_BIT];
				o_side_source_sel     <= aux_modes_q[SOURCE_LSB +: 2];
				o_input_term_on       <= rx_set_q[TERM_ON_BIT];
				o_equalize_level_mask <= eq_mask_q;
				o_out_emphasis_level  <= tx_set_q[EMPHASIS_LSB +: 2];
				o_out_term_on         <= tx_set_q[OUT_TERM_BIT];
				o_out_current_level   <= tx_set_q[OUT_CURRENT_BIT];
			end else begin
				o_fast_path_on        <= pin_f_q[12];
				o_side_path_on        <= 1'b1;
				o_side_source_sel     <= pin_f_q[11:10];
				o_input_term_on       <= 1'b1;
				o_equalize_level_mask <= {16{pin_f_q[9]}};
				o_out_emphasis_level  <= pin_f_q[8:7];
				o_out_term_on         <= pin_f_q[6];
				o_out_current_level   <= pin_f_q[5];
			end
		end
	end

endmodule : vswcfg_regs

// File: hdl/vswcfg_pkg.sv
package vswcfg_pkg;

	// Register offsets
	localparam logic [7:0] HIGH_SPEED_MODES_OFS       = 8'h00;
	localparam logic [7:0] AUXILIARY_MODES_OFS        = 8'h01;
	localparam logic [7:0] RECEIVER_SETTINGS_OFS      = 8'h10;
	localparam logic [7:0] TERMINATION_PULSE_LOW_OFS  = 8'h11;
	localparam logic [7:0] TERMINATION_PULSE_HIGH_OFS = 8'h12;
	localparam logic [7:0] EQUALIZER_LOW_OFS          = 8'h13;
	localparam logic [7:0] EQUALIZER_HIGH_OFS         = 8'h14;
	localparam logic [7:0] TRANSMITTER_SETTINGS_OFS   = 8'h20;

	// Reset values
	localparam logic [7:0] HIGH_SPEED_MODES_RST       = 8'h40;
	localparam logic [7:0] AUXILIARY_MODES_RST        = 8'h40;
	localparam logic [7:0] RECEIVER_SETTINGS_RST      = 8'h01;
	localparam logic [7:0] TERMINATION_PULSE_RST      = 8'h00;
	localparam logic [7:0] EQUALIZER_RST              = 8'h00;
	localparam logic [7:0] TRANSMITTER_SETTINGS_RST   = 8'h03;

	// Field positions
	localparam int ENABLE_BIT      = 6;
	localparam int SOURCE_LSB      = 0;
	localparam int TERM_ON_BIT     = 0;
	localparam int EMPHASIS_LSB    = 2;
	localparam int OUT_TERM_BIT    = 1;
	localparam int OUT_CURRENT_BIT = 0;

	// Writable bits per register; all others read zero
	localparam logic [7:0] MODES_MASK    = 8'h43;
	localparam logic [7:0] RECEIVER_MASK = 8'h01;
	localparam logic [7:0] TX_MASK       = 8'h0F;

	// Fixed upper part of the seven-bit slave address
	localparam logic [3:0] SLAVE_ID_HIGH = 4'h9;

	// Timing
	localparam longint CLK_HZ            = 125000000;
	localparam longint TERM_PULSE_MS     = 100;
	localparam int     TERM_PULSE_CYCLES = int'((TERM_PULSE_MS * CLK_HZ) / 1000);

	typedef enum logic [2:0] {
		VSW_IDLE  = 3'b000,
		VSW_SHIFT = 3'b001,
		VSW_ACK   = 3'b011,
		VSW_SEND  = 3'b010,
		VSW_MACK  = 3'b110
	} vsw_state_t;

endpackage : vswcfg_pkg

// File: test/vswcfg_sva.sv
`timescale 1ns/1ns
module vswcfg_sva #(
	parameter int TERM_PULSE_LEN = 20
) (
	input wire logic        i_clk,
	input wire logic        i_rst,
	input wire logic        i_scl,
	input wire logic        i_par_fast_on,
	input wire logic [1:0]  i_par_source_sel,
	input wire logic        o_sda_out,
	input wire logic        o_sda_oe,
	input wire logic        o_serial_mode,
	input wire logic        o_fast_path_on,
	input wire logic [1:0]  o_fast_source_sel,
	input wire logic        o_side_path_on,
	input wire logic        o_input_term_on,
	input wire logic [15:0] o_term_open_mask
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_rst);
	// Pulse age, counted from the visible source change, so it reaches the timer length at most
	int open_q;
	always_ff @(posedge i_clk) begin
		if (i_rst || o_term_open_mask == 16'h0000 || $changed(o_fast_source_sel)) open_q <= 0;
		else open_q <= open_q + 1;
	end
	property p_no_drive; o_sda_out == 1'b0; endproperty
	a_no_drive: assert property (p_no_drive) else $error("data driven high");
	property p_oe_scl; $changed(o_sda_oe) |-> !i_scl; endproperty
	a_oe_scl: assert property (p_oe_scl) else $error("data moved in clock high");
	property p_mode_ack; $rose(o_serial_mode) |-> o_sda_oe; endproperty
	a_mode_ack: assert property (p_mode_ack) else $error("mode without ack");
	property p_mode_hold; o_serial_mode |=> o_serial_mode; endproperty
	a_mode_hold: assert property (p_mode_hold) else $error("mode dropped");
	property p_rst_out; $fell(i_rst) |-> !o_serial_mode && !o_sda_oe && !o_fast_path_on; endproperty
	a_rst_out: assert property (p_rst_out) else $error("outputs after reset");
	property p_par; (!o_serial_mode && $stable({i_par_fast_on, i_par_source_sel}))[*8]
		|-> {o_fast_path_on, o_fast_source_sel} == {i_par_fast_on, i_par_source_sel}; endproperty
	a_par: assert property (p_par) else $error("pins not followed");
	property p_side; !o_serial_mode && !$past(i_rst) && !$past(i_rst, 2) && !$past(i_rst, 3)
		|-> o_side_path_on && o_input_term_on; endproperty
	a_side: assert property (p_side) else $error("aux path off");
	property p_pulse; open_q <= TERM_PULSE_LEN + 4; endproperty
	a_pulse: assert property (p_pulse) else $error("pulse too long");
endmodule : vswcfg_sva
bind vswcfg_regs vswcfg_sva #(.TERM_PULSE_LEN(TERM_PULSE_LEN)) u_sva (.*);

// File: test/vswcfg_i2c_master.sv
`timescale 1ns/1ns
module vswcfg_i2c_master (
	input wire logic   i_clk,
	input wire logic   i_sda,
	output logic       o_scl,
	output logic       o_sda,
	output logic       o_done,
	output logic [8:0] o_res
);
	initial begin
		{o_scl, o_sda, o_done, o_res} = 12'hC00;
	end
	// Data moves 4 cycles after the clock falls, so both filtered edges never coincide
	task automatic ph(input logic a, input logic b, input logic c, output logic r);
		repeat (4) @(negedge i_clk);
		o_sda = a;
		repeat (10) @(negedge i_clk);
		o_scl = 1'b1;
		repeat (10) @(negedge i_clk);
		o_sda = b;
		repeat (10) @(negedge i_clk);
		r = i_sda;
		o_scl = c;
	endtask : ph
	task automatic byte9(input logic [7:0] b, output logic [8:0] d);
		logic r;
		logic v;
		for (int i = 8; i >= 0; i--) begin
			v = (i > 0) ? b[i - 1] : 1'b1;
			ph(v, v, 1'b0, r);
			d = {d[7:0], r};
		end
	endtask : byte9
	task automatic xfer(input logic [6:0] a, input logic rd, input logic [7:0] ra, input logic [7:0] wd);
		logic [8:0] d;
		logic       n;
		logic       r;
		ph(1'b1, 1'b0, 1'b0, r);
		byte9({a, 1'b0}, d);
		n = d[0];
		byte9(ra, d);
		n = n | d[0];
		if (rd) begin
			ph(1'b1, 1'b0, 1'b0, r);
			byte9({a, 1'b1}, d);
			n = n | d[0];
		end
		byte9(rd ? 8'hFF : wd, d);
		if (!rd) n = n | d[0];
		ph(1'b0, 1'b1, 1'b1, r);
		o_res = {n, d[8:1]};
		o_done = 1'b1;
		@(negedge i_clk);
		o_done = 1'b0;
	endtask : xfer
endmodule : vswcfg_i2c_master

// File: test/test_vswcfg_regs.sv
`timescale 1ns/1ns
module test_vswcfg_regs;
	import vswcfg_pkg::*;
	localparam int LEN = 200;
	logic        i_clk, i_rst, i_scl, m_sda, m_done, o_sda_out, o_sda_oe, o_serial_mode;
	logic        i_slave_id_strap2, i_slave_id_strap1, i_slave_id_strap0, o_fast_path_on, o_side_path_on;
	logic        i_par_fast_on, i_par_equalize, i_par_out_term, i_par_out_current;
	logic        o_input_term_on, o_out_term_on, o_out_current_level;
	logic [1:0]  i_par_source_sel, i_par_emphasis, o_fast_source_sel, o_side_source_sel, o_out_emphasis_level;
	logic [15:0] o_term_open_mask, o_equalize_level_mask;
	logic [8:0]  m_res, q[$];
	logic [7:0]  ofs[8] = '{8'h00, 8'h01, 8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h20};
	logic [7:0]  msk[8] = '{8'h43, 8'h43, 8'h01, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h0F};
	logic [7:0]  rstv[8] = '{8'h40, 8'h40, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h03};
	logic [7:0]  cur[8];
	logic [31:0] s;
	logic [6:0]  adr;
	int          n_errors = 0;
	int          comparisons = 0;
	wire         i_sda = m_sda & ~o_sda_oe;
	vswcfg_regs #(.TERM_PULSE_LEN(LEN)) dut (.*);
	vswcfg_i2c_master m (.i_clk(i_clk), .i_sda(i_sda), .o_scl(i_scl), .o_sda(m_sda), .o_done(m_done), .o_res(m_res));
	function automatic logic [31:0] lfsr(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction : lfsr
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_errors++;
			$display("unexpected %s: expected %h, seen %h", nm, exp, seen);
		end
	endtask : check
	task automatic summarize;
		$display("%0d comparisons, %0d mismatches", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : summarize
	task automatic randpar;
		s = lfsr(s);
		{i_par_fast_on, i_par_source_sel, i_par_equalize, i_par_emphasis, i_par_out_term, i_par_out_current} = s[7:0];
	endtask : randpar
	task automatic outs(input logic sm);
		logic [26:0] v;
		logic [26:0] e;
		repeat (10) @(negedge i_clk);
		v = {o_fast_path_on, o_fast_source_sel, o_side_path_on, o_side_source_sel, o_input_term_on,
			o_equalize_level_mask, o_out_emphasis_level, o_out_term_on, o_out_current_level};
		e = sm ? {cur[0][6], cur[0][1:0], cur[1][6], cur[1][1:0], cur[2][0], cur[6], cur[5], cur[7][3:0]}
			: {i_par_fast_on, i_par_source_sel, 1'b1, i_par_source_sel, 1'b1, {16{i_par_equalize}},
			i_par_emphasis, i_par_out_term, i_par_out_current};
		check("serial mode", o_serial_mode, sm);
		check("settings", v, e);
	endtask : outs
	task automatic rw(input int k, input logic rd, input logic [7:0] d);
		if (!rd) cur[k] = d & msk[k];
		q.push_back({1'b0, rd ? cur[k] : d});
		m.xfer(adr, rd, ofs[k], d);
	endtask : rw
	always @(posedge i_clk) begin
		if (m_done === 1'b1) check("reply", m_res, q.pop_front());
	end
	initial begin
		i_clk = 1'b0;
		forever #4 i_clk = ~i_clk;
	end
	initial begin
		#600000;
		n_errors++;
		summarize;
	end
	initial begin
		s = 32'h0000FBEE;
		i_rst = 1'b1;
		randpar;
		{i_slave_id_strap2, i_slave_id_strap1, i_slave_id_strap0} = s[10:8];
		adr = {SLAVE_ID_HIGH, s[10:8]};
		cur = rstv;
		repeat (3) @(negedge i_clk);
		i_rst = 1'b0;
		outs(1'b0);
		randpar;
		outs(1'b0);
		$display("parallel test done");
		for (int k = 0; k < 8; k++) rw(k, 1'b1, 8'h00);
		q.push_back(9'h000);
		m.xfer(adr, 1'b1, 8'h30, 8'h00);
		randpar;
		outs(1'b1);
		$display("default test done");
		for (int k = 0; k < 8; k++) begin
			s = lfsr(s);
			rw(k, 1'b0, s[7:0]);
			rw(k, 1'b1, 8'h00);
			outs(1'b1);
		end
		$display("read back test done");
		for (int i = 0; i < 4; i++) begin
			rw(0, 1'b0, {1'b0, i[0], 4'h0, i[1:0]});
			rw(1, 1'b0, {1'b0, ~i[0], 4'h0, i[1:0]});
			outs(1'b1);
		end
		$display("source test done");
		rw(3, 1'b0, 8'hA5);
		rw(4, 1'b0, 8'h3C);
		rw(0, 1'b0, cur[0] ^ 8'h01);
		check("open mask", o_term_open_mask, {cur[4], cur[3]});
		repeat (LEN) @(negedge i_clk);
		check("open mask", o_term_open_mask, 16'h0000);
		rw(0, 1'b0, cur[0]);
		check("open mask", o_term_open_mask, 16'h0000);
		$display("pulse test done");
		q.push_back(9'h1FF);
		m.xfer(adr ^ 7'h01, 1'b0, 8'h13, 8'hFF);
		rw(5, 1'b1, 8'h00);
		$display("address test done");
		i_rst = 1'b1;
		repeat (3) @(negedge i_clk);
		i_rst = 1'b0;
		cur = rstv;
		outs(1'b0);
		$display("second reset test done");
		summarize;
	end
endmodule : test_vswcfg_regs
